// File: rtl/ovp_regs.svh
`ifndef OVP_REGS_SVH
`define OVP_REGS_SVH

// ==========================================================
// timing
`define OVP_CLK_PERIOD_NS 4
`define OVP_MS_NS 1000000
`define OVP_FORCE_TIMEOUT_MIN 5
`define OVP_MS_PER_MIN 60000

// ==========================================================
// register offsets (byte addresses)
`define OVP_REG_FORCE 12'h000
`define OVP_REG_GROUP 12'h004
`define OVP_REG_STATUS 12'h008
`define OVP_REG_UMAX 12'h00c
`define OVP_REG_IRQ_STATUS 12'h010
`define OVP_REG_IRQ_CLEAR 12'h014
`define OVP_REG_IRQ_ENABLE 12'h018
`define OVP_REG_CNT_CLEAR 12'h01c
`define OVP_REG_TIME_MS 12'h020
`define OVP_REG_NOMINAL 12'h024
`define OVP_REG_REC_SEL 12'h028
`define OVP_REG_REC_TIME 12'h02c
`define OVP_REG_REC_DATA 12'h030
`define OVP_REG_COUNT_BASE 12'h040
`define OVP_REG_PRIMARY_BASE 12'h050
`define OVP_REG_STAGE_STRIDE 12'h004
// settings window: base + group*0x40 + stage*0x10 + field*4
`define OVP_SET_PAGE 4'h1
`define OVP_FLD_PICKUP 2'h0
`define OVP_FLD_DELAY 2'h1
`define OVP_FLD_HYST 2'h2
`define OVP_FLD_RELEASE 2'h3

// ==========================================================
// field positions
`define OVP_FORCE_ON_BIT 0
`define OVP_FORCE_START_LSB 1
`define OVP_FORCE_TRIP_LSB 4
`define OVP_GRP_MANUAL_LSB 0
`define OVP_GRP_SOURCE_LSB 2
`define OVP_GRP_INDEX_LSB 5
`define OVP_GRP_ALT_LSB 9
`define OVP_GRP_ACTIVE_LSB 16
`define OVP_CNT_CLR_TRIP_LSB 3
`define OVP_REC_IDX_LSB 2
`define OVP_REC_ELAPSED_DELAY_PCT_LSB 16
`define OVP_REC_GRP_LSB 24
`define OVP_REC_VALID_BIT 31
`define OVP_IRQ_TRIP_LSB 3

// ==========================================================
// scaling and reset values
`define OVP_HYST_FULL 10'd1000
`define OVP_PCT_FULL 8'd100
`define OVP_PRIMARY_DIV 32'd10000
`define OVP_PICKUP_RST 16'h2ee0
`define OVP_DELAY_RST 16'h03e8
`define OVP_HYST_RST 8'h1e
`define OVP_RELEASE_RST 16'h0000
`define OVP_NOMINAL_RST 16'h2710

`endif

// File: rtl/ovp_pkg.sv
package ovp_pkg;

    typedef enum logic [2:0] {
        OVP_SRC_NONE,
        OVP_SRC_DIGITAL,
        OVP_SRC_VIRTUAL,
        OVP_SRC_INDICATOR,
        OVP_SRC_VOUT
    } ovp_source_t;

    typedef struct packed {
        logic [15:0] u12;
        logic [15:0] u23;
        logic [15:0] u31;
    } ovp_volts_t;

    typedef struct packed {
        logic [31:0] stamp;
        logic [15:0] volt;
        logic [7:0] elapsed_delay_pct;
        logic [1:0] grp;
        logic valid;
    } ovp_rec_t;

    typedef struct packed {
        logic [17:0] tick_cnt;
        logic [31:0] time_ms;
        logic force_on;
        logic [18:0] force_cnt;
        logic [2:0] forced_start;
        logic [2:0] forced_trip;
        logic [1:0] manual_group;
        logic [1:0] alt_group;
        ovp_source_t sel_source;
        logic [3:0] sel_index;
        logic [1:0] active_group;
        logic [15:0] nominal;
        logic [3:0][2:0][15:0] pickup;
        logic [3:0][2:0][15:0] delay;
        logic [3:0][2:0][7:0] hyst;
        logic [3:0][15:0] release_delay;
        logic [15:0] umax;
        logic [2:0] fault;
        logic [2:0] trip;
        logic [2:0] blocked;
        logic [2:0] start_o;
        logic [2:0] trip_o;
        logic [2:0][15:0] op_cnt;
        logic [15:0] rel_cnt;
        logic [2:0][15:0] start_event_count;
        logic [2:0][15:0] trip_event_count;
        logic [2:0][15:0] fault_max;
        logic [2:0][1:0] fault_grp;
        logic [2:0][7:0][58:0] rec;
        logic [2:0][2:0] rec_wptr;
        logic [5:0] irq_status;
        logic [5:0] irq_enable;
        logic irq;
        logic [1:0] rec_stage;
        logic [2:0] rec_idx;
        logic [31:0] rdata;
    } ovp_state_t;

endpackage

// File: rtl/ovp_top.sv
// The implementer's own choices: the plain strobed port and the address map.
`timescale 1ns/1ps
`include "ovp_regs.svh"

// What this block does
// R1: supervise fundamental line-to-line voltages only, never phase-to-ground values
// R2: stage starts as soon as any line-to-line voltage exceeds its pick-up
// R3: trip when pick-up persists longer than the operate delay
// R4: three independent stages, each with own pick-up and definite delay
// R5: first stage keeps its delay count until release delay fully elapses
// R6: first stage resumes from retained count when fault returns early
// R7: picked-up stage holds until voltage drops below pick-up minus hysteresis
// R8: four setting groups per stage, active one chosen by input or manually
// R9: group source is none, digital, virtual, indicator or virtual output
// R10: status blocked, start or trip; start/trip writable only while forced
// R11: one shared force flag, auto-cleared five minutes after being set
// R12: per-stage start and trip counters, each clearable to zero
// R13: expose supervised value as the maximum of three line voltages
// R14: pick-up in percent of nominal, also shown in primary volts
// R15: operator must present a password before changing any setting; the code has no password check, any write changes a setting
// R16: eight latest fault records per stage: time, voltage, group, elapsed percent
// R17: any stage can be blocked by a routed signal and reports blocked
// R18: fault records form a ring, newest replaces oldest when full
// R19: trip and trip count once per episode; trip clears on release
module ovp_top #(
    parameter int MS_CYCLES = `OVP_MS_NS / `OVP_CLK_PERIOD_NS,
    parameter int FORCE_TIMEOUT_MS = `OVP_FORCE_TIMEOUT_MIN * `OVP_MS_PER_MIN
) (
    input wire logic clk, // 250 MHz clock
    input wire logic rst_b, // async reset, active low
    input wire ovp_pkg::ovp_volts_t volts, // fundamental line-to-line magnitudes, 0.01 % of nominal
    input wire logic [2:0] stage_block, // blocking per stage, high blocks
    input wire logic [15:0] digital_input_n, // digital inputs for group select
    input wire logic [15:0] virtual_input_n, // virtual inputs for group select
    input wire logic [15:0] indicator_signal_n, // indicator signals for group select
    input wire logic [15:0] virtual_output_n, // virtual outputs for group select
    input wire logic [11:0] addr, // register byte address
    input wire logic [31:0] wdata, // write data
    input wire logic wr, // write strobe
    input wire logic rd, // read strobe
    output logic [31:0] rdata, // read data, cycle after rd
    output logic [2:0] start_out, // start per stage
    output logic [2:0] trip_out, // trip per stage
    output logic [2:0] blocked_out, // blocked status per stage
    output logic [15:0] umax_out, // supervised maximum voltage
    output logic irq // level interrupt
);

    ovp_pkg::ovp_state_t q;
    ovp_pkg::ovp_state_t next_q;

    // ==========================================================
    // helpers
    function automatic logic [15:0] max3(input ovp_pkg::ovp_volts_t v);
        logic [15:0] m;
        m = (v.u12 > v.u23) ? v.u12 : v.u23;
        return (v.u31 > m) ? v.u31 : m;
    endfunction

    // release level = pick-up * (1000 - hyst) / 1000, hyst in 0.1 % and limited to 200
    function automatic logic [15:0] release_level(input logic [15:0] pk, input logic [7:0] hy);
        logic [25:0] prod;
        logic [9:0] keep;
        keep = (hy > 8'd200) ? 10'd800 : (`OVP_HYST_FULL - {2'b00, hy});
        prod = {10'h000, pk} * {16'h0000, keep};
        return 16'(prod / 26'(`OVP_HYST_FULL));
    endfunction

    // settings window decode: {hit, group, stage, field}
    function automatic logic [6:0] set_decode(input logic [11:0] a);
        logic hit;
        hit = (a[11:8] == `OVP_SET_PAGE) && (a[5:4] != 2'h3) && (a[1:0] == 2'h0);
        return {hit, a[7:6], a[5:4], a[3:2]};
    endfunction

    function automatic logic [31:0] primary_volts(input logic [15:0] pk, input logic [15:0] nom);
        logic [31:0] prod;
        prod = {16'h0000, pk} * {16'h0000, nom};
        return prod / `OVP_PRIMARY_DIV;
    endfunction

    // ==========================================================
    // next state
    always_comb begin
        logic tick;
        logic sel_bit;
        logic flt;
        logic [1:0] g;
        logic [15:0] pk;
        logic [15:0] rel;
        logic [6:0] dec;
        logic [23:0] pct;
        logic [2:0] ri;
        ovp_pkg::ovp_rec_t r;
        tick = 1'b0;
        sel_bit = 1'b0;
        flt = 1'b0;
        g = 2'h0;
        pk = 16'h0000;
        rel = 16'h0000;
        pct = 24'h000000;
        ri = 3'h0;
        r = '0;
        dec = set_decode(addr);
        next_q = q;

        // millisecond time base and time stamp clock
        tick = (q.tick_cnt == 18'(MS_CYCLES - 1));
        next_q.tick_cnt = tick ? 18'h00000 : q.tick_cnt + 18'h00001;
        if (tick) begin
            next_q.time_ms = q.time_ms + 32'h00000001;
        end

        next_q.umax = max3(volts); // see R1, see R13

        // group selection from the configured source
        case (q.sel_source)
            ovp_pkg::OVP_SRC_DIGITAL: sel_bit = digital_input_n[q.sel_index];
            ovp_pkg::OVP_SRC_VIRTUAL: sel_bit = virtual_input_n[q.sel_index];
            ovp_pkg::OVP_SRC_INDICATOR: sel_bit = indicator_signal_n[q.sel_index];
            ovp_pkg::OVP_SRC_VOUT: sel_bit = virtual_output_n[q.sel_index];
            default: sel_bit = 1'b0;
        endcase
        next_q.active_group = sel_bit ? q.alt_group : q.manual_group; // see R8, see R9

        // force flag timeout
        if (q.force_on) begin
            if (tick) begin
                next_q.force_cnt = q.force_cnt + 19'h00001;
            end
            if (q.force_cnt >= 19'(FORCE_TIMEOUT_MS)) begin
                next_q.force_on = 1'b0; // see R11
                next_q.forced_start = 3'h0;
                next_q.forced_trip = 3'h0;
            end
        end

        // ==========================================================
        // register writes
        if (wr) begin
            if (addr == `OVP_REG_FORCE) begin
                next_q.force_on = wdata[`OVP_FORCE_ON_BIT];
                next_q.force_cnt = 19'h00000;
                if (q.force_on && wdata[`OVP_FORCE_ON_BIT]) begin
                    next_q.forced_start = wdata[`OVP_FORCE_START_LSB +: 3]; // see R10
                    next_q.forced_trip = wdata[`OVP_FORCE_TRIP_LSB +: 3];
                end else begin
                    next_q.forced_start = 3'h0;
                    next_q.forced_trip = 3'h0;
                end
            end else if (addr == `OVP_REG_GROUP) begin
                next_q.manual_group = wdata[`OVP_GRP_MANUAL_LSB +: 2];
                next_q.sel_source = (wdata[`OVP_GRP_SOURCE_LSB +: 3] > 3'(ovp_pkg::OVP_SRC_VOUT)) ?
                    ovp_pkg::OVP_SRC_NONE : ovp_pkg::ovp_source_t'(wdata[`OVP_GRP_SOURCE_LSB +: 3]);
                next_q.sel_index = wdata[`OVP_GRP_INDEX_LSB +: 4];
                next_q.alt_group = wdata[`OVP_GRP_ALT_LSB +: 2];
            end else if (addr == `OVP_REG_IRQ_CLEAR) begin
                next_q.irq_status = q.irq_status & ~wdata[5:0];
            end else if (addr == `OVP_REG_IRQ_ENABLE) begin
                next_q.irq_enable = wdata[5:0];
            end else if (addr == `OVP_REG_CNT_CLEAR) begin
                for (int s = 0; s < 3; s++) begin
                    if (wdata[s]) begin
                        next_q.start_event_count[s] = 16'h0000; // see R12
                    end
                    if (wdata[`OVP_CNT_CLR_TRIP_LSB + s]) begin
                        next_q.trip_event_count[s] = 16'h0000;
                    end
                end
            end else if (addr == `OVP_REG_TIME_MS) begin
                next_q.time_ms = wdata;
            end else if (addr == `OVP_REG_NOMINAL) begin
                next_q.nominal = wdata[15:0];
            end else if (addr == `OVP_REG_REC_SEL) begin
                next_q.rec_stage = (wdata[1:0] == 2'h3) ? 2'h0 : wdata[1:0];
                next_q.rec_idx = wdata[`OVP_REC_IDX_LSB +: 3];
            end else if (dec[6]) begin
                case (dec[1:0])
                    `OVP_FLD_PICKUP: next_q.pickup[dec[5:4]][dec[3:2]] = wdata[15:0];
                    `OVP_FLD_DELAY: next_q.delay[dec[5:4]][dec[3:2]] = wdata[15:0];
                    `OVP_FLD_HYST: next_q.hyst[dec[5:4]][dec[3:2]] = wdata[7:0];
                    default: begin
                        if (dec[3:2] == 2'h0) begin
                            next_q.release_delay[dec[5:4]] = wdata[15:0];
                        end
                    end
                endcase
            end
        end

        // ==========================================================
        // stages; event sets come after clears so a same-cycle event wins
        g = q.active_group;
        for (int s = 0; s < 3; s++) begin
            pk = q.pickup[g][s];
            rel = release_level(pk, q.hyst[g][s]);
            flt = q.fault[s] ? (q.umax >= rel) : (q.umax > pk); // see R2, see R7
            if (stage_block[s]) begin
                flt = 1'b0; // see R17
            end
            next_q.fault[s] = flt;
            next_q.blocked[s] = stage_block[s];
            if (flt) begin
                if (!q.fault[s]) begin
                    next_q.start_event_count[s] = next_q.start_event_count[s] + 16'h0001; // see R12
                    next_q.irq_status[s] = 1'b1;
                    next_q.fault_max[s] = q.umax;
                    next_q.fault_grp[s] = g;
                end else if (q.umax > q.fault_max[s]) begin
                    next_q.fault_max[s] = q.umax;
                end
                if (s == 0) begin
                    next_q.rel_cnt = 16'h0000; // see R6
                end
                if (tick && !q.trip[s] && q.op_cnt[s] != 16'hffff) begin
                    next_q.op_cnt[s] = q.op_cnt[s] + 16'h0001;
                end
                if (!q.trip[s] && q.op_cnt[s] >= q.delay[g][s]) begin
                    next_q.trip[s] = 1'b1; // see R3, see R4, see R19
                    next_q.trip_event_count[s] = next_q.trip_event_count[s] + 16'h0001;
                    next_q.irq_status[`OVP_IRQ_TRIP_LSB + s] = 1'b1;
                end
            end else begin
                next_q.trip[s] = 1'b0; // see R19
                if (s == 0 && !stage_block[s]) begin
                    // intermittent faults accumulate until the release delay runs out
                    if (q.op_cnt[0] != 16'h0000) begin
                        if (q.rel_cnt >= q.release_delay[g]) begin
                            next_q.op_cnt[0] = 16'h0000; // see R5
                            next_q.rel_cnt = 16'h0000;
                        end else if (tick) begin
                            next_q.rel_cnt = q.rel_cnt + 16'h0001;
                        end
                    end
                end else begin
                    next_q.op_cnt[s] = 16'h0000;
                    if (s == 0) begin
                        next_q.rel_cnt = 16'h0000;
                    end
                end
                if (q.fault[s]) begin
                    // episode ended: write record at the ring pointer
                    pct = ({8'h00, q.op_cnt[s]} * 24'(`OVP_PCT_FULL)) /
                        ((q.delay[q.fault_grp[s]][s] == 16'h0000) ? 24'h000001 : {8'h00, q.delay[q.fault_grp[s]][s]});
                    r.stamp = q.time_ms;
                    r.volt = q.fault_max[s];
                    r.elapsed_delay_pct = (q.trip[s] || pct >= 24'(`OVP_PCT_FULL)) ? `OVP_PCT_FULL : pct[7:0]; // see R16
                    r.grp = q.fault_grp[s];
                    r.valid = 1'b1;
                    next_q.rec[s][q.rec_wptr[s]] = r;
                    next_q.rec_wptr[s] = q.rec_wptr[s] + 3'h1; // see R18
                end
            end
        end

        next_q.start_o = next_q.fault | (next_q.force_on ? next_q.forced_start : 3'h0); // see R10
        next_q.trip_o = next_q.trip | (next_q.force_on ? next_q.forced_trip : 3'h0);
        next_q.irq = |(next_q.irq_status & next_q.irq_enable);

        // ==========================================================
        // register reads
        next_q.rdata = 32'h00000000;
        if (rd) begin
            if (addr == `OVP_REG_FORCE) begin
                next_q.rdata = {25'h0, q.forced_trip, q.forced_start, q.force_on};
            end else if (addr == `OVP_REG_GROUP) begin
                next_q.rdata = {14'h0, q.active_group, 5'h0, q.alt_group, q.sel_index, q.sel_source,
                    q.manual_group};
            end else if (addr == `OVP_REG_STATUS) begin
                next_q.rdata = {23'h0, q.trip_o[2], q.start_o[2], q.blocked[2], q.trip_o[1], q.start_o[1],
                    q.blocked[1], q.trip_o[0], q.start_o[0], q.blocked[0]};
            end else if (addr == `OVP_REG_UMAX) begin
                next_q.rdata = {16'h0, q.umax}; // see R13
            end else if (addr == `OVP_REG_IRQ_STATUS) begin
                next_q.rdata = {26'h0, q.irq_status};
            end else if (addr == `OVP_REG_IRQ_ENABLE) begin
                next_q.rdata = {26'h0, q.irq_enable};
            end else if (addr == `OVP_REG_TIME_MS) begin
                next_q.rdata = q.time_ms;
            end else if (addr == `OVP_REG_NOMINAL) begin
                next_q.rdata = {16'h0, q.nominal};
            end else if (addr == `OVP_REG_REC_SEL) begin
                next_q.rdata = {27'h0, q.rec_idx, q.rec_stage};
            end else if (addr == `OVP_REG_REC_TIME || addr == `OVP_REG_REC_DATA) begin
                // index 0 is the newest record
                ri = q.rec_wptr[q.rec_stage] - 3'h1 - q.rec_idx;
                r = q.rec[q.rec_stage][ri];
                if (addr == `OVP_REG_REC_TIME) begin
                    next_q.rdata = r.stamp;
                end else begin
                    next_q.rdata = {r.valid, 5'h0, r.grp, r.elapsed_delay_pct, r.volt};
                end
            end else if (addr >= `OVP_REG_COUNT_BASE && addr < `OVP_REG_COUNT_BASE + 12'h00c && addr[1:0] == 2'h0) begin
                next_q.rdata = {q.trip_event_count[addr[3:2]], q.start_event_count[addr[3:2]]};
            end else if (addr >= `OVP_REG_PRIMARY_BASE && addr < `OVP_REG_PRIMARY_BASE + 12'h00c
                && addr[1:0] == 2'h0) begin
                next_q.rdata = primary_volts(q.pickup[g][addr[3:2]], q.nominal); // see R14
            end else if (dec[6]) begin
                case (dec[1:0])
                    `OVP_FLD_PICKUP: next_q.rdata = {16'h0, q.pickup[dec[5:4]][dec[3:2]]};
                    `OVP_FLD_DELAY: next_q.rdata = {16'h0, q.delay[dec[5:4]][dec[3:2]]};
                    `OVP_FLD_HYST: next_q.rdata = {24'h0, q.hyst[dec[5:4]][dec[3:2]]};
                    default: next_q.rdata = (dec[3:2] == 2'h0) ? {16'h0, q.release_delay[dec[5:4]]} : 32'h0;
                endcase
            end
        end
    end

    // ==========================================================
    // state register
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            q <= '0;
            q.sel_source <= ovp_pkg::OVP_SRC_NONE;
            q.nominal <= `OVP_NOMINAL_RST;
            q.pickup <= {12{`OVP_PICKUP_RST}};
            q.delay <= {12{`OVP_DELAY_RST}};
            q.hyst <= {12{`OVP_HYST_RST}};
            q.release_delay <= {4{`OVP_RELEASE_RST}};
        end else begin
            q <= next_q;
        end
    end

    assign rdata = q.rdata;
    assign start_out = q.start_o;
    assign trip_out = q.trip_o;
    assign blocked_out = q.blocked;
    assign umax_out = q.umax;
    assign irq = q.irq;

endmodule

// File: dv/ovp_meas_model.sv
`timescale 1ns/1ps
module ovp_meas_model (
    input wire logic clk, // clock
    input wire logic rst_b, // reset, active low
    input wire logic [15:0] level, // level of the disturbed line
    input wire logic [1:0] line, // which line is disturbed
    output ovp_pkg::ovp_volts_t volts // line-to-line magnitudes
);
    // ==========
    // front end: healthy lines sit at nominal, no phase-to-ground values
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            volts <= '0;
        end else begin
            volts.u12 <= (line == 2'h0) ? level : 16'h2710;
            volts.u23 <= (line == 2'h1) ? level : 16'h2710;
            volts.u31 <= (line == 2'h2) ? level : 16'h2710;
        end
    end
endmodule

// File: dv/ovp_top_props.sv
`timescale 1ns/1ps
`include "ovp_regs.svh"
module ovp_props (
    input wire logic clk, // clock
    input wire logic rst_b, // reset
    input wire ovp_pkg::ovp_volts_t volts, // lines
    input wire logic [2:0] stage_block, // block
    input wire logic [15:0] digital_input_n, // select
    input wire logic [15:0] virtual_input_n, // select
    input wire logic [15:0] indicator_signal_n, // select
    input wire logic [15:0] virtual_output_n, // select
    input wire logic [11:0] addr, // bus
    input wire logic [31:0] wdata, // bus
    input wire logic wr, // bus
    input wire logic rd, // bus
    input wire logic [31:0] rdata, // bus
    input wire logic [2:0] start_out, // start
    input wire logic [2:0] trip_out, // trip
    input wire logic [2:0] blocked_out, // blocked
    input wire logic [15:0] umax_out, // max
    input wire logic irq // irq
);
    logic forced_q;
    logic pk_dirty;
    logic [15:0] vmax;
    logic [8:0] stat;
    // ==========
    // helpers: sticky on purpose, timeouts only make them conservative
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            forced_q <= 1'b0;
            pk_dirty <= 1'b0;
        end else if (wr) begin
            if (addr == `OVP_REG_FORCE) forced_q <= wdata[0];
            if (addr[11:8] == 4'h1 && addr[3:2] == 2'h0) pk_dirty <= 1'b1;
        end
    end
    always_comb begin
        vmax = (volts.u12 > volts.u23) ? volts.u12 : volts.u23;
        if (volts.u31 > vmax) vmax = volts.u31;
    end
    assign stat = {trip_out[2], start_out[2], blocked_out[2], trip_out[1], start_out[1], blocked_out[1],
        trip_out[0], start_out[0], blocked_out[0]};
    // ==========
    // properties
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    sequence s_rd_at(logic [11:0] a);
        rd && addr == a;
    endsequence
    sequence s_over_default;
        (!pk_dirty && stage_block == 3'h0 && vmax > `OVP_PICKUP_RST) [*3];
    endsequence
    a_umax_max: assert property ($past(rst_b) |-> umax_out == $past(vmax)) else $error("umax not max");
    a_umax_read: assert property (s_rd_at(`OVP_REG_UMAX) |=> rdata == {16'h0000, $past(umax_out)})
        else $error("umax read wrong");
    a_status_mirror: assert property (s_rd_at(`OVP_REG_STATUS) |=> rdata[8:0] == $past(stat))
        else $error("status read wrong");
    a_rdata_idle: assert property (!rd |=> rdata == 32'h0) else $error("rdata not idle");
    a_blocked_copy: assert property ($past(rst_b) |-> blocked_out == $past(stage_block)) else $error("block");
    a_block_quiet: assert property ((!forced_q && stage_block[2]) [*4] |-> !start_out[2] && !trip_out[2])
        else $error("blocked stage active");
    a_trip_start: assert property (!forced_q |-> (trip_out & ~start_out) == 3'h0) else $error("trip alone");
    a_start_fast: assert property (s_over_default |-> start_out == 3'h7) else $error("start late");
endmodule
bind ovp_top ovp_props u_props (.*);

// File: dv/tb_ovp_top.sv
`timescale 1ns/1ps
`include "ovp_regs.svh"
module tb_ovp_top;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [2:0] stage_block = 3'h0;
    logic [3:0][15:0] sel = '0;
    logic [11:0] addr = 12'h000;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [15:0] level = 16'h2710;
    logic [1:0] line = 2'h1;
    ovp_pkg::ovp_volts_t volts;
    logic [31:0] rdata;
    logic [2:0] start_out, trip_out, blocked_out;
    logic [15:0] umax_out;
    logic irq;
    int err_total = 0;
    int n_tests = 0;
    always #2 clk = ~clk;
    ovp_meas_model u_ovp_meas_model (.clk(clk), .rst_b(rst_b), .level(level), .line(line), .volts(volts));
    ovp_top #(.MS_CYCLES(10), .FORCE_TIMEOUT_MS(3)) u_ovp_top (.clk(clk), .rst_b(rst_b), .volts(volts),
        .stage_block(stage_block), .digital_input_n(sel[0]), .virtual_input_n(sel[1]),
        .indicator_signal_n(sel[2]), .virtual_output_n(sel[3]), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .start_out(start_out), .trip_out(trip_out), .blocked_out(blocked_out),
        .umax_out(umax_out), .irq(irq));
    task automatic report_and_stop();
        $display("checks %0d errors %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // ==========
    // bus and output helpers, every call starts and ends on a rising edge
    task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        chk(rdata, exp);
        @(posedge clk);
    endtask
    task automatic out_chk(input logic [2:0] s, input logic [2:0] t);
        @(negedge clk);
        chk({26'h0, start_out, trip_out}, {26'h0, s, t});
        @(posedge clk);
    endtask
    task automatic wait_trip(input logic [2:0] m);
        int k = 0;
        while ((trip_out & m) !== m && k < 400) begin
            @(negedge clk);
            k++;
        end
        chk({31'h0, k < 400}, 32'h1);
        @(posedge clk);
    endtask
    initial begin
        #100us;
        err_total++;
        report_and_stop();
    end
    // ==========
    // main sequence
    initial begin
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        rd_chk(12'h108, 32'h1e);
        rd_chk(12'hffc, 32'h0);
        wr_reg(`OVP_REG_NOMINAL, 32'h4e20);
        rd_chk(`OVP_REG_PRIMARY_BASE, 32'h5dc0);
        wr_reg(12'h104, 32'h3);
        wr_reg(12'h114, 32'h6);
        wr_reg(12'h124, 32'hffff);
        wr_reg(`OVP_REG_IRQ_ENABLE, 32'h3f);
        level <= 16'h3000;
        repeat (4) @(posedge clk);
        out_chk(3'h7, 3'h0);
        wait_trip(3'h1);
        out_chk(3'h7, 3'h1);
        wait_trip(3'h2);
        out_chk(3'h7, 3'h3);
        rd_chk(`OVP_REG_UMAX, 32'h3000);
        rd_chk(`OVP_REG_STATUS, 32'hb6);
        @(negedge clk);
        chk({31'h0, irq}, 32'h1);
        @(posedge clk);
        level <= 16'h2e00;
        repeat (6) @(posedge clk);
        out_chk(3'h7, 3'h3);
        level <= 16'h2d00;
        repeat (5) @(posedge clk);
        out_chk(3'h0, 3'h0);
        rd_chk(`OVP_REG_COUNT_BASE, 32'h00010001);
        rd_chk(12'h048, 32'h00000001);
        rd_chk(`OVP_REG_IRQ_STATUS, 32'h1f);
        wr_reg(`OVP_REG_IRQ_CLEAR, 32'h3f);
        rd_chk(`OVP_REG_IRQ_STATUS, 32'h0);
        wr_reg(`OVP_REG_REC_SEL, 32'h0);
        rd_chk(`OVP_REG_REC_DATA, 32'h80643000);
        wr_reg(`OVP_REG_CNT_CLEAR, 32'h09);
        rd_chk(`OVP_REG_COUNT_BASE, 32'h0);
        // each pulse alone is too short to trip stage 0
        wr_reg(12'h104, 32'h5);
        wr_reg(12'h10c, 32'd20);
        stage_block <= 3'h6;
        level <= 16'h3000;
        repeat (35) @(posedge clk);
        level <= 16'h2000;
        repeat (25) @(posedge clk);
        level <= 16'h3000;
        repeat (38) @(posedge clk);
        out_chk(3'h1, 3'h1);
        @(negedge clk);
        chk({29'h0, blocked_out}, 32'h6);
        @(posedge clk);
        level <= 16'h2000;
        repeat (260) @(posedge clk);
        level <= 16'h3000;
        repeat (38) @(posedge clk);
        out_chk(3'h1, 3'h0);
        level <= 16'h2000;
        wr_reg(12'h180, 32'h4000);
        for (int s = 0; s < 5; s++) begin
            sel <= (s == 0) ? 64'h0008000800080008 : 64'h8 << (16 * (s - 1));
            wr_reg(`OVP_REG_GROUP, 32'h461 | (s << 2));
            rd_chk(`OVP_REG_GROUP, 32'h461 | (s << 2) | ((s == 0 ? 1 : 2) << 16));
        end
        line <= 2'h2;
        level <= 16'h3000;
        repeat (4) @(posedge clk);
        out_chk(3'h0, 3'h0);
        level <= 16'h2000;
        wr_reg(`OVP_REG_FORCE, 32'h7e);
        out_chk(3'h0, 3'h0);
        wr_reg(`OVP_REG_FORCE, 32'h1);
        wr_reg(`OVP_REG_FORCE, 32'h7f);
        out_chk(3'h7, 3'h7);
        repeat (45) @(posedge clk);
        out_chk(3'h0, 3'h0);
        rd_chk(`OVP_REG_FORCE, 32'h0);
        report_and_stop();
    end
endmodule
